// [pkg/pwr_mgmt_pkg.sv]
// Shared constants for management interrupt and stop clock control
package pwr_mgmt_pkg;
	// Stop grant special cycle encoding
	localparam logic [31:0] STOP_GRANT_ADDR = 32'h0000_0010;
	localparam logic [7:0] STOP_GRANT_BE_N = 8'hFB;
	localparam logic STOP_GRANT_MIO = 1'h0;
	localparam logic STOP_GRANT_DC = 1'h0;
	localparam logic STOP_GRANT_WR = 1'h1;
	// Least request pulse and gap widths, in clocks
	localparam int REQ_MIN_CLKS = 2;
	localparam logic [1:0] SYNC_RESET = 2'h3;
	// Device sequencer states
	typedef enum logic [3:0] {
		ST_RUN,
		ST_SMI_DRAIN,
		ST_SMM,
		ST_STP_DRAIN,
		ST_STP_CYCLE,
		ST_STP_GRANT
	} dev_state_t;
endpackage

// [pkg/pwr_mgmt_if.sv]
// Link between the processor end and the chipset end
`timescale 1ns/1ps
interface pwr_mgmt_if;
	logic mgmt_irq_req_n;
	logic stop_clock_req_n;
	logic ext_write_buf_empty_n;
	logic mgmt_active_n;
	logic addr_strobe_n;
	logic cyc_mio;
	logic cyc_dc;
	logic cyc_wr;
	logic [31:0] cyc_addr;
	logic [7:0] byte_en_n;
	logic hold_ack;
	logic maskable_irq;
	logic maskable_irq_ack;

	// Processor end
	modport dev (
		input mgmt_irq_req_n, stop_clock_req_n, ext_write_buf_empty_n,
		input maskable_irq,
		output mgmt_active_n, addr_strobe_n, cyc_mio, cyc_dc, cyc_wr,
		output cyc_addr, byte_en_n, hold_ack, maskable_irq_ack
	);
	// Chipset end
	modport host (
		output mgmt_irq_req_n, stop_clock_req_n, ext_write_buf_empty_n,
		output maskable_irq,
		input mgmt_active_n, addr_strobe_n, cyc_mio, cyc_dc, cyc_wr,
		input cyc_addr, byte_en_n, hold_ack, maskable_irq_ack
	);
endinterface

// [design/req_sync.sv]
// Two flop synchroniser for an asynchronous active low request
`timescale 1ns/1ps
module req_sync (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic req_n_i,
	output logic req_n_o
);
	logic [1:0] sync_r;

	// Stage 0 feeds only stage 1
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync_r <= pwr_mgmt_pkg::SYNC_RESET;
		end else if (ce_i) begin
			sync_r <= {sync_r[0], req_n_i};
		end
	end

	assign req_n_o = sync_r[1];
endmodule

// [design/pwr_mgmt_dev.sv]
// Processor end: management mode entry/exit and stop clock sequencing
`timescale 1ns/1ps
module pwr_mgmt_dev (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	pwr_mgmt_if.dev link,
	input wire logic instr_boundary_i,
	input wire logic pipe_empty_i,
	input wire logic bus_idle_i,
	input wire logic resume_instr_i,
	input wire logic dual_mode_i,
	input wire logic bus_owner_i,
	input wire logic bus_hold_req_i,
	input wire logic debug_exc_i,
	input wire logic snoop_req_i,
	input wire logic ack_irq_i,
	output logic smm_o,
	output logic take_debug_o,
	output logic take_irq_o,
	output logic core_clk_en_o,
	output logic snoop_ack_o,
	output logic irq_pending_o
);
	logic smi_n_s;
	logic stp_n_s;
	logic smi_prev_r;
	logic stp_prev_r;
	logic smi_fall;
	logic smi_pend_r;
	logic smi_latched_r;
	logic stp_rise;
	logic irq_latch_r;
	logic hold_ack_r;
	logic ads_n_r;
	logic grant_go;
	pwr_mgmt_pkg::dev_state_t state_r;

	// ------------------------------------------------------------
	// Request synchronisers
	// ------------------------------------------------------------
	req_sync u_smi_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.req_n_i(link.mgmt_irq_req_n),
		.req_n_o(smi_n_s)
	);
	req_sync u_stp_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.req_n_i(link.stop_clock_req_n),
		.req_n_o(stp_n_s)
	);

	// Edge history of synchronised requests
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			smi_prev_r <= 1'h1;
			stp_prev_r <= 1'h1;
		end else if (ce_i) begin
			smi_prev_r <= smi_n_s;
			stp_prev_r <= stp_n_s;
		end
	end

	assign smi_fall = smi_prev_r & ~smi_n_s;
	assign stp_rise = ~stp_prev_r & stp_n_s;

	// Drain done: the grant cycle launches on this edge
	assign grant_go = state_r == pwr_mgmt_pkg::ST_STP_DRAIN &&
		pipe_empty_i && bus_idle_i && !hold_ack_r &&
		!link.ext_write_buf_empty_n;

	// ------------------------------------------------------------
	// Management request capture
	// ------------------------------------------------------------
	// Pending edge in normal mode, single latched edge in mode
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			smi_pend_r <= 1'h0;
			smi_latched_r <= 1'h0;
		end else if (ce_i) begin
			if (state_r == pwr_mgmt_pkg::ST_SMM) begin
				if (smi_fall) begin
					smi_latched_r <= 1'h1;
				end
				if (resume_instr_i) begin
					smi_pend_r <= smi_latched_r | smi_fall;
					smi_latched_r <= 1'h0;
				end
			end else if (smi_fall) begin
				smi_pend_r <= 1'h1;
			end else if (state_r == pwr_mgmt_pkg::ST_SMI_DRAIN) begin
				smi_pend_r <= 1'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus hold acknowledge
	// ------------------------------------------------------------
	// Grant bus while idle in any state but ST_STP_CYCLE and no cycle of ours is out
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hold_ack_r <= 1'h0;
		end else if (ce_i) begin
			// No grant on the edge that launches our own cycle
			hold_ack_r <= bus_hold_req_i && bus_idle_i && !grant_go &&
				state_r != pwr_mgmt_pkg::ST_STP_CYCLE;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= pwr_mgmt_pkg::ST_RUN;
		end else if (ce_i) begin
			unique case (state_r)
				pwr_mgmt_pkg::ST_RUN: begin
					if (instr_boundary_i && smi_pend_r) begin
						state_r <= pwr_mgmt_pkg::ST_SMI_DRAIN;
					end else if (instr_boundary_i && !stp_n_s &&
						!link.maskable_irq && !hold_ack_r) begin
						state_r <= pwr_mgmt_pkg::ST_STP_DRAIN;
					end
				end
				pwr_mgmt_pkg::ST_SMI_DRAIN: begin
					if (bus_idle_i && !link.ext_write_buf_empty_n) begin
						state_r <= pwr_mgmt_pkg::ST_SMM;
					end
				end
				pwr_mgmt_pkg::ST_SMM: begin
					if (resume_instr_i) begin
						state_r <= pwr_mgmt_pkg::ST_RUN;
					end
				end
				pwr_mgmt_pkg::ST_STP_DRAIN: begin
					if (grant_go) begin
						state_r <= pwr_mgmt_pkg::ST_STP_CYCLE;
					end
				end
				pwr_mgmt_pkg::ST_STP_CYCLE: begin
					state_r <= pwr_mgmt_pkg::ST_STP_GRANT;
				end
				pwr_mgmt_pkg::ST_STP_GRANT: begin
					if (stp_rise) begin
						state_r <= pwr_mgmt_pkg::ST_RUN;
					end
				end
				default: begin
					state_r <= pwr_mgmt_pkg::ST_RUN;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Interrupt latch during stop grant
	// ------------------------------------------------------------
	// Held until acknowledge; set wins over clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_latch_r <= 1'h0;
		end else if (ce_i) begin
			if (state_r == pwr_mgmt_pkg::ST_STP_GRANT && link.maskable_irq) begin
				irq_latch_r <= 1'h1;
			end else if (ack_irq_i) begin
				irq_latch_r <= 1'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Stop grant special cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ads_n_r <= 1'h1;
		end else if (ce_i) begin
			ads_n_r <= !grant_go;
		end
	end

	// Constant cycle encoding, data left undefined
	assign link.cyc_mio = pwr_mgmt_pkg::STOP_GRANT_MIO;
	assign link.cyc_dc = pwr_mgmt_pkg::STOP_GRANT_DC;
	assign link.cyc_wr = pwr_mgmt_pkg::STOP_GRANT_WR;
	assign link.cyc_addr = pwr_mgmt_pkg::STOP_GRANT_ADDR;
	assign link.byte_en_n = pwr_mgmt_pkg::STOP_GRANT_BE_N;
	assign link.addr_strobe_n = ads_n_r;
	assign link.hold_ack = hold_ack_r;
	assign link.maskable_irq_ack = ack_irq_i;

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Always driven; owner gating in dual mode
	assign link.mgmt_active_n = !(state_r == pwr_mgmt_pkg::ST_SMM &&
		(!dual_mode_i || bus_owner_i));
	assign smm_o = state_r == pwr_mgmt_pkg::ST_SMM;
	assign take_debug_o = instr_boundary_i && debug_exc_i &&
		state_r == pwr_mgmt_pkg::ST_RUN && !smi_pend_r;
	assign take_irq_o = instr_boundary_i &&
		(link.maskable_irq || irq_latch_r) &&
		state_r == pwr_mgmt_pkg::ST_RUN && !smi_pend_r;
	assign core_clk_en_o = state_r != pwr_mgmt_pkg::ST_STP_GRANT;
	assign snoop_ack_o = snoop_req_i;
	assign irq_pending_o = irq_latch_r;
endmodule

// [design/pwr_mgmt_host.sv]
// Chipset end: drives requests, watches management active
`timescale 1ns/1ps
module pwr_mgmt_host (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	pwr_mgmt_if.host link,
	input wire logic smi_pulse_i,
	input wire logic stop_req_i,
	input wire logic irq_i,
	input wire logic writes_done_i,
	output logic smm_seen_o,
	output logic stop_granted_o,
	output logic busy_o
);
	logic [1:0] cnt_r;
	logic smi_n_r;
	logic stp_n_r;
	logic irq_r;
	logic smm_seen_r;
	logic granted_r;

	// SMI pulse: low for two clocks then high for two
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 2'h0;
			smi_n_r <= 1'h1;
		end else if (ce_i) begin
			if (cnt_r != 2'h0) begin
				cnt_r <= cnt_r - 2'h1;
				if (cnt_r == 2'h2) begin
					smi_n_r <= 1'h1;
				end
			end else if (smi_pulse_i) begin
				smi_n_r <= 1'h0;
				cnt_r <= 2'(2 * pwr_mgmt_pkg::REQ_MIN_CLKS - 1);
			end
		end
	end

	// Stop request driven high, never floated
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stp_n_r <= 1'h1;
		end else if (ce_i) begin
			stp_n_r <= !stop_req_i;
		end
	end

	// Hold interrupt until acknowledge
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_r <= 1'h0;
		end else if (ce_i) begin
			if (irq_i) begin
				irq_r <= 1'h1;
			end else if (link.maskable_irq_ack) begin
				irq_r <= 1'h0;
			end
		end
	end

	// Qualify active with address strobe
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			smm_seen_r <= 1'h0;
			granted_r <= 1'h0;
		end else if (ce_i) begin
			if (!link.addr_strobe_n) begin
				smm_seen_r <= !link.mgmt_active_n;
			end
			if (!link.addr_strobe_n && link.cyc_wr && !link.cyc_mio &&
				link.cyc_addr == pwr_mgmt_pkg::STOP_GRANT_ADDR &&
				link.byte_en_n == pwr_mgmt_pkg::STOP_GRANT_BE_N) begin
				granted_r <= 1'h1;
			end else if (!stop_req_i) begin
				granted_r <= 1'h0;
			end
		end
	end

	assign link.mgmt_irq_req_n = smi_n_r;
	assign link.stop_clock_req_n = stp_n_r;
	assign link.ext_write_buf_empty_n = !writes_done_i;
	assign link.maskable_irq = irq_r;
	assign smm_seen_o = smm_seen_r;
	assign stop_granted_o = granted_r;
	assign busy_o = cnt_r != 2'h0;
endmodule

// [tb/pwr_mgmt_chk.sv]
// Checker for the management and stop clock link
`timescale 1ns/1ps
module pwr_mgmt_chk (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic mgmt_irq_req_n,
	input wire logic stop_clock_req_n,
	input wire logic ext_write_buf_empty_n,
	input wire logic mgmt_active_n,
	input wire logic addr_strobe_n,
	input wire logic cyc_mio,
	input wire logic cyc_dc,
	input wire logic cyc_wr,
	input wire logic [31:0] cyc_addr,
	input wire logic [7:0] byte_en_n,
	input wire logic hold_ack,
	input wire logic maskable_irq,
	input wire logic maskable_irq_ack
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// ----------------------------------------
	// Link properties
	// ----------------------------------------
	a_active_needs_empty: assert property (
		$fell(mgmt_active_n) |-> !$past(ext_write_buf_empty_n))
		else $error("active while write buffer busy");
	a_smi_sync_delay: assert property (
		$fell(mgmt_irq_req_n) && mgmt_active_n |=> mgmt_active_n [*3])
		else $error("request used before synchronising");
	a_req_pulse_width: assert property (
		$fell(mgmt_irq_req_n) |=> !mgmt_irq_req_n)
		else $error("request pulse too short");
	a_req_gap_width: assert property (
		$rose(mgmt_irq_req_n) |=> mgmt_irq_req_n)
		else $error("request gap too short");
	a_grant_encoding: assert property (
		!addr_strobe_n |-> {cyc_mio, cyc_dc, cyc_wr, cyc_addr, byte_en_n}
		== {1'h0, 1'h0, 1'h1, 32'h0000_0010, 8'hFB})
		else $error("grant cycle encoding wrong");
	a_grant_one_clock: assert property (
		!addr_strobe_n |=> addr_strobe_n)
		else $error("grant strobe longer than one clock");
	a_grant_after_empty: assert property (
		$fell(addr_strobe_n) |->
		!stop_clock_req_n && !$past(ext_write_buf_empty_n))
		else $error("grant without request or empty buffer");
	a_no_grant_in_hold: assert property (
		!addr_strobe_n |-> !hold_ack)
		else $error("grant cycle while bus handed away");
endmodule

// [tb/smm_and_stop_clock_control_tb_top.sv]
// Bench joining processor end and chipset end
`timescale 1ns/1ps
module smm_and_stop_clock_control_tb_top;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic idle, own, mgmt_resume_instr, hreq, dbg, snp, ack, smi, stp, irq, wd;
	logic smm, cen, sak, ipend, gnt, busy, tdbg, tirq;
	int bad_count = 0;
	int n_compared = 0;
	int i;

	// ----------------------------------------
	// Clock, link and both ends
	// ----------------------------------------
	always #2.5 clk_i = ~clk_i;
	pwr_mgmt_if link ();
	pwr_mgmt_dev i_pwr_mgmt_dev (.clk_i(clk_i), .reset_i(reset_i),
		.ce_i(1'h1), .link(link), .instr_boundary_i(1'h1),
		.pipe_empty_i(1'h1), .bus_idle_i(idle), .resume_instr_i(mgmt_resume_instr),
		.dual_mode_i(1'h0), .bus_owner_i(own), .bus_hold_req_i(hreq),
		.debug_exc_i(dbg), .snoop_req_i(snp), .ack_irq_i(ack),
		.smm_o(smm), .take_debug_o(tdbg), .take_irq_o(tirq),
		.core_clk_en_o(cen), .snoop_ack_o(sak), .irq_pending_o(ipend));
	pwr_mgmt_host i_pwr_mgmt_host (.clk_i(clk_i), .reset_i(reset_i),
		.ce_i(1'h1), .link(link), .smi_pulse_i(smi), .stop_req_i(stp),
		.irq_i(irq), .writes_done_i(wd), .smm_seen_o(),
		.stop_granted_o(gnt), .busy_o(busy));
	pwr_mgmt_chk i_pwr_mgmt_chk (.clk_i(clk_i), .reset_i(reset_i),
		.mgmt_irq_req_n(link.mgmt_irq_req_n),
		.stop_clock_req_n(link.stop_clock_req_n),
		.ext_write_buf_empty_n(link.ext_write_buf_empty_n),
		.mgmt_active_n(link.mgmt_active_n),
		.addr_strobe_n(link.addr_strobe_n), .cyc_mio(link.cyc_mio),
		.cyc_dc(link.cyc_dc), .cyc_wr(link.cyc_wr),
		.cyc_addr(link.cyc_addr), .byte_en_n(link.byte_en_n),
		.hold_ack(link.hold_ack), .maskable_irq(link.maskable_irq),
		.maskable_irq_ack(link.maskable_irq_ack));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, g);
		n_compared++;
		if (e !== g) begin
			bad_count++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	function automatic logic sig(input int k);
		sig = (k == 0) ? link.mgmt_active_n :
			(k == 1) ? link.addr_strobe_n : cen;
	endfunction
	// Bounded wait for a watched signal to reach a level
	task automatic await(input int k, input logic v);
		for (i = 0; i < 60 && sig(k) !== v; i++) tick(1);
		if (i >= 60) begin
			chk("wait", 0, 1);
			test_done();
		end
	endtask
	task automatic pulse_smi();
		smi = 1'h1;
		tick(1);
		smi = 1'h0;
		for (i = 0; i < 60 && busy !== 1'h0; i++) tick(1);
		if (i >= 60) begin
			chk("busy", 0, 1);
			test_done();
		end
	endtask
	task automatic resume();
		mgmt_resume_instr = 1'h1;
		tick(1);
		mgmt_resume_instr = 1'h0;
		chk("exit", 1, link.mgmt_active_n);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_smi();
		wd = 1'h0;
		dbg = 1'h1;
		tick(1);
		chk("dbg free", 1, tdbg);
		pulse_smi();
		chk("dbg masked", 0, tdbg);
		dbg = 1'h0;
		tick(8);
		chk("early", 1, link.mgmt_active_n);
		wd = 1'h1;
		await(0, 1'h0);
		chk("smm", 1, smm);
		pulse_smi();
		pulse_smi();
		tick(4);
		chk("held", 0, link.mgmt_active_n);
		resume();
		await(0, 1'h0);
		resume();
		tick(20);
		chk("dropped", 1, link.mgmt_active_n);
		$display("t_smi done");
	endtask
	task automatic t_stop();
		irq = 1'h1;
		tick(1);
		irq = 1'h0;
		stp = 1'h1;
		tick(20);
		chk("refused", 1, cen);
		chk("irq held", 1, link.maskable_irq);
		ack = 1'h1;
		tick(1);
		ack = 1'h0;
		await(1, 1'h0);
		chk("cycle", {1'h0, 1'h0, 1'h1, 32'h0000_0010, 8'hFB},
			{link.cyc_mio, link.cyc_dc, link.cyc_wr, link.cyc_addr,
			link.byte_en_n});
		tick(1);
		chk("clk off", 0, cen);
		snp = 1'h1;
		tick(1);
		chk("snoop", 1, sak);
		snp = 1'h0;
		irq = 1'h1;
		tick(1);
		irq = 1'h0;
		tick(3);
		chk("latched", 1, ipend);
		chk("still off", 0, cen);
		chk("granted", 1, gnt);
		stp = 1'h0;
		await(2, 1'h1);
		chk("irq served", 1, tirq);
		ack = 1'h1;
		tick(1);
		ack = 1'h0;
		tick(3);
		$display("t_stop done");
	endtask
	task automatic t_hold();
		hreq = 1'h1;
		tick(3);
		chk("hold", 1, link.hold_ack);
		stp = 1'h1;
		tick(20);
		chk("no stop", 1, cen);
		hreq = 1'h0;
		await(1, 1'h0);
		stp = 1'h0;
		await(2, 1'h1);
		$display("t_hold done");
	endtask

	// Main sequence
	initial begin
		{idle, own} = 2'h3;
		{mgmt_resume_instr, hreq, dbg, snp, ack, smi, stp, irq, wd} = 9'h000;
		tick(10);
		reset_i = 1'h0;
		tick(2);
		t_smi();
		t_stop();
		t_hold();
		test_done();
	end
endmodule
